// ==== verilog/bbrb_cfg.svh ====
/*
  register offsets, field positions, reset values and timing counts of the
  battery-backed register bank.
  assumes: included by the bank package users; definitions only.
*/
`ifndef BBRB_CFG_SVH
`define BBRB_CFG_SVH

// ==========================================================================
// offsets
`define BBRB_OFF_STATUS   8'h00
`define BBRB_OFF_TEST_A   8'h04
`define BBRB_OFF_CLKEN    8'h08
`define BBRB_OFF_TEST_B   8'h10
`define BBRB_OFF_TEST_C   8'h14
`define BBRB_OFF_OUTDOM   8'h18
`define BBRB_OFF_TEST_D   8'h1C

// ==========================================================================
// status fields
`define BBRB_ST_BATT      7
`define BBRB_ST_WDOG      5
`define BBRB_ST_DET       0

// ==========================================================================
// clock enable fields
`define BBRB_CK_REFSEL    5
`define BBRB_CK_SWDIS     4
`define BBRB_CK_EMUL      3
`define BBRB_CK_INTEN     2
`define BBRB_CK_EXTEN     1
`define BBRB_CK_XTYPE     0
`define BBRB_CLKEN_RST    6'h00

// ==========================================================================
// output domain fields
`define BBRB_OD_GEN       1
`define BBRB_OD_CTRL      0
`define BBRB_OUTDOM_RST   2'h3

// ==========================================================================
// switcher timing: good external edges before returning, and the number of
// system clocks without an external edge that counts as a stopped clock
`define BBRB_GOOD_EDGES   4'h8
`define BBRB_STOP_NS      40000
`define BBRB_CLK_NS       10
`define BBRB_STOP_CYC     (`BBRB_STOP_NS / `BBRB_CLK_NS)

`endif

// ==== verilog/bbrb_pkg.sv ====
/*
  types of the battery-backed register bank.
  assumes: nothing beyond a SystemVerilog compiler.
*/
package bbrb_pkg;

  // ========================================================================
  // slow clock source on the output
  typedef enum logic [2:0] {
    BBRB_SRC_OFF  = 3'b000,
    BBRB_SRC_XTAL = 3'b001,
    BBRB_SRC_SE   = 3'b010,
    BBRB_SRC_INT  = 3'b011,
    BBRB_SRC_SW   = 3'b100
  } bbrb_src_e;

  // ========================================================================
  // switcher state
  typedef enum logic [1:0] {
    BBRB_SW_EXT   = 2'b00,
    BBRB_SW_INT   = 2'b01,
    BBRB_SW_CHECK = 2'b10
  } bbrb_sw_e;

endpackage : bbrb_pkg

// ==== verilog/bbrb_bank.sv ====
/*
  battery-backed register bank: power-fail and reset status, slow clock
  source control and switcher, supply domain of two battery output pins.
  assumes: one system clock at 100 MHz, a synchronous active-high reset that
  is the battery power-on reset, an 8-bit address register port from the
  controller on the same clock, raw crystal and single-ended clock levels
  from the pads, and a watchdog reset pulse on the same clock.
*/
`timescale 1ns/1ps
`include "bbrb_cfg.svh"

// Operation
// - battery reset flag bit 7 sets on battery power-on reset, default one.
// - battery reset flag clears only on a one-write; zero-writes ignored.
// - watchdog flag bit 5 sets after watchdog reset, default zero.
// - watchdog flag clears on one-write, unchanged on zero-write.
// - read-only bit 0 shows whether a crystal clock is detected.
// - power-fail event output reflects battery reset and watchdog flags.
// - battery power-on reset is the only reset of all bank state.
// - all register accesses run on the controller bus clock.
// - clock bit 5 picks 48 MHz reference: external or switched slow clock.
// - switcher falls to internal on external stop, returns after good edges.
// - switching only while main rail on; emulation bit rules otherwise.
// - bit 4 one disables switcher, single enabled source only.
// - bit 3 zero keeps internal oscillator on rail-off; one gates it.
// - bit 2 enables internal slow oscillator.
// - bit 1 enables the external source chosen by type select.
// - bit 0 one single-ended on second pin; zero crystal, default.
// - source table: disabled, crystal, internal per enable combination.
// - switched mode: external with rail on, internal on stop or rail drop.
// - single-ended, switcher off, external on: external regardless of internal.
// - alternate bit 1 picks battery or rail domain for general output.
// - alternate bit 0 picks battery or rail domain for control output.
module bbrb_bank
  import bbrb_pkg::*;
(
  input  wire logic       SYS_CLK,
  input  wire logic       SYS_RST,
  input  wire logic       CLK_EN,
  input  wire logic [7:0] REG_ADDR,
  input  wire logic       REG_WR,
  input  wire logic       REG_RD,
  input  wire logic [31:0] REG_WDATA,
  output logic      [31:0] REG_RDATA,
  input  wire logic       WATCHDOG_RESET,
  input  wire logic       MAIN_SUPPLY_RAIL,
  input  wire logic       FIRST_CRYSTAL_PIN,
  input  wire logic       SECOND_CRYSTAL_PIN,
  input  wire logic       GENERAL_BATT_VALUE,
  input  wire logic       GENERAL_PIN_CTRL,
  input  wire logic       CTRL_BATT_VALUE,
  input  wire logic       CTRL_PIN_CTRL,
  output logic            POWER_FAIL_EVENT,
  output logic            XTAL_OSC_EN,
  output logic            SE_INPUT_EN,
  output logic            INT_OSC_EN,
  output logic            SLOW_CLK_OUT,
  output logic            REF_USES_SWITCHED,
  output logic [2:0]      SLOW_SRC,
  output logic            BATTERY_GENERAL_OUTPUT,
  output logic            BATTERY_GENERAL_OUTPUT_OE_N,
  output logic            BATTERY_CONTROL_OUTPUT,
  output logic            BATTERY_CONTROL_OUTPUT_OE_N
);

  // ========================================================================
  // pin synchronisers, one lane per pad; only the second flop is read
  logic [2:0] sync1_reg;
  logic [2:0] sync2_reg;
  logic       se_last_reg;
  logic       xt_last_reg;
  logic [1:0] prime_reg;
  wire  [2:0] pin_raw = {MAIN_SUPPLY_RAIL, SECOND_CRYSTAL_PIN,
                         FIRST_CRYSTAL_PIN};

  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_sync
      always_ff @(posedge SYS_CLK) begin
        if (SYS_RST) begin
          sync1_reg[gi] <= 1'b0;
          sync2_reg[gi] <= 1'b0;
        end else if (CLK_EN) begin
          sync1_reg[gi] <= pin_raw[gi];
          sync2_reg[gi] <= sync1_reg[gi];
        end
      end
    end
  endgenerate

  // edges count only once the pipeline holds real pad levels, so a pad
  // resting high at reset release is not taken for a rising edge
  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      se_last_reg <= 1'b0;
      xt_last_reg <= 1'b0;
      prime_reg   <= 2'h0;
    end else if (CLK_EN) begin
      se_last_reg <= sync2_reg[1];
      xt_last_reg <= sync2_reg[0];
      if (prime_reg != 2'h3) begin
        prime_reg <= prime_reg + 2'h1;
      end
    end
  end

  wire primed   = (prime_reg == 2'h3);
  wire rail_on  = sync2_reg[2];
  wire se_edge  = primed & sync2_reg[1] & ~se_last_reg;
  wire xt_edge  = primed & sync2_reg[0] & ~xt_last_reg;

  // ========================================================================
  // register decode
  wire hit_status = (REG_ADDR == `BBRB_OFF_STATUS);
  wire hit_clken  = (REG_ADDR == `BBRB_OFF_CLKEN);
  wire hit_outdom = (REG_ADDR == `BBRB_OFF_OUTDOM);
  wire wr_status  = REG_WR & hit_status;
  wire wr_clken   = REG_WR & hit_clken;
  wire wr_outdom  = REG_WR & hit_outdom;

  // ========================================================================
  // status flags; set wins over a clear in the same cycle
  logic batt_flag_reg;
  logic wdog_flag_reg;
  logic det_reg;
  wire  batt_clr  = wr_status & REG_WDATA[`BBRB_ST_BATT];
  wire  wdog_clr  = wr_status & REG_WDATA[`BBRB_ST_WDOG];
  wire  wdog_next = WATCHDOG_RESET | (wdog_flag_reg & ~wdog_clr);

  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      batt_flag_reg <= 1'b1;
      wdog_flag_reg <= 1'b0;
    end else if (CLK_EN) begin
      if (batt_clr) begin
        batt_flag_reg <= 1'b0;
      end
      wdog_flag_reg <= wdog_next;
    end
  end

  assign POWER_FAIL_EVENT = batt_flag_reg | wdog_flag_reg;

  // ========================================================================
  // crystal detect: an edge on either pad within the stop window
  localparam int STOP_CYC = `BBRB_STOP_CYC;
  logic [15:0] det_cnt_reg;
  logic [15:0] se_cnt_reg;

  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      det_cnt_reg <= 16'h0000;
      det_reg     <= 1'b0;
    end else if (CLK_EN) begin
      if (xt_edge | se_edge) begin
        det_cnt_reg <= 16'h0000;
        det_reg     <= 1'b1;
      end else if (det_cnt_reg == 16'(STOP_CYC)) begin
        det_reg     <= 1'b0;
      end else begin
        det_cnt_reg <= det_cnt_reg + 16'h0001;
      end
    end
  end

  // ========================================================================
  // clock enable and output domain registers
  logic [5:0] clken_reg;
  logic [1:0] outdom_reg;

  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      clken_reg  <= `BBRB_CLKEN_RST;
      outdom_reg <= `BBRB_OUTDOM_RST;
    end else if (CLK_EN) begin
      if (wr_clken) begin
        clken_reg <= REG_WDATA[5:0];
      end
      if (wr_outdom) begin
        outdom_reg <= REG_WDATA[1:0];
      end
    end
  end

  wire ref_sel = clken_reg[`BBRB_CK_REFSEL];
  wire sw_dis  = clken_reg[`BBRB_CK_SWDIS];
  wire emul    = clken_reg[`BBRB_CK_EMUL];
  wire int_en  = clken_reg[`BBRB_CK_INTEN];
  wire ext_en  = clken_reg[`BBRB_CK_EXTEN];
  wire xtype   = clken_reg[`BBRB_CK_XTYPE];

  // ========================================================================
  // source selection; external wins over internal except in switched mode, where the switcher picks; only one drives
  wire use_xtal  = ext_en & ~xtype;
  wire use_se    = ext_en & xtype & (sw_dis | ~int_en);
  wire use_sw    = ext_en & xtype & ~sw_dis & int_en;
  wire use_int   = ~ext_en & int_en;
  bbrb_src_e src;
  assign src = use_xtal ? BBRB_SRC_XTAL :
               use_se   ? BBRB_SRC_SE   :
               use_sw   ? BBRB_SRC_SW   :
               use_int  ? BBRB_SRC_INT  : BBRB_SRC_OFF;

  // ========================================================================
  // switcher: stop detect and good-edge count on the single-ended pad
  bbrb_sw_e   sw_reg;
  logic [3:0] good_reg;
  wire        se_stopped = (se_cnt_reg == 16'(STOP_CYC));

  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      sw_reg     <= BBRB_SW_EXT;
      good_reg   <= 4'h0;
      se_cnt_reg <= 16'h0000;
    end else if (CLK_EN) begin
      if (se_edge) begin
        se_cnt_reg <= 16'h0000;
      end else if (!se_stopped) begin
        se_cnt_reg <= se_cnt_reg + 16'h0001;
      end
      unique case (sw_reg)
        BBRB_SW_EXT: begin
          if (se_stopped) begin
            sw_reg <= BBRB_SW_INT;
          end
        end
        BBRB_SW_INT: begin
          good_reg <= 4'h0;
          if (se_edge) begin
            sw_reg <= BBRB_SW_CHECK;
          end
        end
        BBRB_SW_CHECK: begin
          if (se_stopped) begin
            sw_reg <= BBRB_SW_INT;
          end else if (se_edge) begin
            if (good_reg == `BBRB_GOOD_EDGES - 4'h1) begin
              sw_reg <= BBRB_SW_EXT;
            end else begin
              good_reg <= good_reg + 4'h1;
            end
          end
        end
        default: begin
          sw_reg <= BBRB_SW_INT;
        end
      endcase
    end
  end

  // switching only acts with rail on; rail off always falls to internal
  wire sw_pick_ext = rail_on & (sw_reg == BBRB_SW_EXT);
  // internal oscillator gated when rail is off under rail emulation
  wire int_run   = ~(emul & ~rail_on);

  // ========================================================================
  // outputs
  assign XTAL_OSC_EN  = (src == BBRB_SRC_XTAL);
  assign SE_INPUT_EN  = (src == BBRB_SRC_SE) | (src == BBRB_SRC_SW);
  assign INT_OSC_EN   = ((src == BBRB_SRC_INT) |
                         ((src == BBRB_SRC_SW) & ~sw_pick_ext))
                        & int_run;
  assign SLOW_SRC     = (src == BBRB_SRC_SW) ?
                        (sw_pick_ext ? BBRB_SRC_SE : BBRB_SRC_INT) : src;
  assign SLOW_CLK_OUT = (SLOW_SRC == BBRB_SRC_XTAL) ? sync2_reg[0] :
                        (SLOW_SRC == BBRB_SRC_SE)   ? sync2_reg[1] :
                        1'b0;
  assign REF_USES_SWITCHED = ref_sel;

  // supply domain of the two battery outputs; OE_N low means driving
  assign BATTERY_GENERAL_OUTPUT = outdom_reg[`BBRB_OD_GEN] ?
                                  GENERAL_BATT_VALUE :
                                  GENERAL_PIN_CTRL;
  assign BATTERY_GENERAL_OUTPUT_OE_N = ~(outdom_reg[`BBRB_OD_GEN] |
                                         rail_on);
  assign BATTERY_CONTROL_OUTPUT = outdom_reg[`BBRB_OD_CTRL] ?
                                  CTRL_BATT_VALUE : CTRL_PIN_CTRL;
  assign BATTERY_CONTROL_OUTPUT_OE_N = ~(outdom_reg[`BBRB_OD_CTRL] |
                                         rail_on);

  // ========================================================================
  // read data, registered; unmapped and test offsets read zero
  wire [31:0] rd_mux =
    hit_status ? {24'h000000, batt_flag_reg, 1'b0, wdog_flag_reg, 4'h0,
                  det_reg} :
    hit_clken  ? {26'h0000000, clken_reg} :
    hit_outdom ? {30'h00000000, outdom_reg} : 32'h00000000;

  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      REG_RDATA <= 32'h00000000;
    end else if (CLK_EN && REG_RD) begin
      REG_RDATA <= rd_mux;
    end
  end

endmodule : bbrb_bank

// ==== dv/bbrb_pad_model.sv ====
/* slow clock pad source for the bank's crystal pins.
   assumes: run and se_mode are levels from the bench. */
`timescale 1ns/1ps
module bbrb_pad_model #(
  parameter int HALF_NS = 500
) (
  input  wire logic run,
  input  wire logic se_mode,
  output logic      first_pin,
  output logic      second_pin
);
  // ==========================================================
  // pads
  // a stopped source holds its last level, like a dead oscillator
  logic ph = 1'b0;
  always begin
    #(HALF_NS);
    if (run) ph = ~ph;
  end
  assign second_pin = ph;
  assign first_pin  = se_mode ? 1'b0 : ~ph;
endmodule : bbrb_pad_model

// ==== dv/bbrb_bank_assertions.sv ====
/* port checker of the battery-backed register bank.
   assumes: bound to bbrb_bank; one clock, sync reset. */
`timescale 1ns/1ps
`include "bbrb_cfg.svh"
module bbrb_bank_assertions (
  input wire logic        SYS_CLK,
  input wire logic        SYS_RST,
  input wire logic        CLK_EN,
  input wire logic [7:0]  REG_ADDR,
  input wire logic        REG_WR,
  input wire logic        REG_RD,
  input wire logic [31:0] REG_WDATA,
  input wire logic [31:0] REG_RDATA,
  input wire logic        WATCHDOG_RESET,
  input wire logic        MAIN_SUPPLY_RAIL,
  input wire logic        CTRL_BATT_VALUE,
  input wire logic        POWER_FAIL_EVENT,
  input wire logic        SLOW_CLK_OUT,
  input wire logic [2:0]  SLOW_SRC,
  input wire logic        BATTERY_GENERAL_OUTPUT_OE_N,
  input wire logic        BATTERY_CONTROL_OUTPUT,
  input wire logic        BATTERY_CONTROL_OUTPUT_OE_N
);
  // ==========================================================
  // helpers
  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (SYS_RST);
  logic [1:0] alt_reg;
  wire st_wr = CLK_EN && REG_WR && REG_ADDR == `BBRB_OFF_STATUS;
  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST) alt_reg <= `BBRB_OUTDOM_RST;
    else if (CLK_EN && REG_WR && REG_ADDR == `BBRB_OFF_OUTDOM)
      alt_reg <= REG_WDATA[1:0];
  end
  sequence clear_both;
    st_wr && REG_WDATA[7] && REG_WDATA[5] && !WATCHDOG_RESET;
  endsequence
  sequence rail_off_held;
    (!alt_reg[1] && !MAIN_SUPPLY_RAIL) [*4];
  endsequence
  // ==========================================================
  // checks
  rst_flag_a: assert property ($fell(SYS_RST) |-> POWER_FAIL_EVENT)
    else $error("event low after reset");
  wdog_set_a: assert property (WATCHDOG_RESET && CLK_EN |=> POWER_FAIL_EVENT)
    else $error("watchdog did not raise event");
  flag_clear_a: assert property (clear_both |=> !POWER_FAIL_EVENT)
    else $error("one-write did not clear flags");
  flag_keep_a: assert property (st_wr && !REG_WDATA[7] && !REG_WDATA[5]
    && POWER_FAIL_EVENT |=> POWER_FAIL_EVENT) else $error("zero-write cleared");
  rdata_hold_a: assert property (!(REG_RD && CLK_EN) |=> $stable(REG_RDATA))
    else $error("read data moved without read");
  src_range_a: assert property (SLOW_SRC <= 3'h3)
    else $error("slow source code out of range");
  src_quiet_a: assert property (SLOW_SRC inside {3'h0, 3'h3} |-> !SLOW_CLK_OUT)
    else $error("pad clock on output while off or internal");
  gpo_float_a: assert property (rail_off_held |-> BATTERY_GENERAL_OUTPUT_OE_N)
    else $error("general output driven with rail off");
  ctl_batt_a: assert property (alt_reg[0] && $stable(alt_reg) &&
    $stable(CTRL_BATT_VALUE) && !$past(SYS_RST) |-> !BATTERY_CONTROL_OUTPUT_OE_N
    && BATTERY_CONTROL_OUTPUT == CTRL_BATT_VALUE) else $error("control pin");
endmodule : bbrb_bank_assertions

bind bbrb_bank bbrb_bank_assertions u_chk (.SYS_CLK(SYS_CLK), .SYS_RST(SYS_RST),
  .CLK_EN(CLK_EN), .REG_ADDR(REG_ADDR), .REG_WR(REG_WR), .REG_RD(REG_RD),
  .REG_WDATA(REG_WDATA), .REG_RDATA(REG_RDATA), .WATCHDOG_RESET(WATCHDOG_RESET),
  .MAIN_SUPPLY_RAIL(MAIN_SUPPLY_RAIL), .CTRL_BATT_VALUE(CTRL_BATT_VALUE),
  .POWER_FAIL_EVENT(POWER_FAIL_EVENT), .SLOW_CLK_OUT(SLOW_CLK_OUT),
  .SLOW_SRC(SLOW_SRC),
  .BATTERY_GENERAL_OUTPUT_OE_N(BATTERY_GENERAL_OUTPUT_OE_N),
  .BATTERY_CONTROL_OUTPUT(BATTERY_CONTROL_OUTPUT),
  .BATTERY_CONTROL_OUTPUT_OE_N(BATTERY_CONTROL_OUTPUT_OE_N));

// ==== dv/bbrb_bank_tb_top.sv ====
/* self-checking bench of the battery-backed register bank.
   assumes: the bank, its package and the pad model are compiled first. */
`timescale 1ns/1ps
module bbrb_bank_tb_top
  import bbrb_pkg::*;
;
  // ==========================================================
  // stimulus state
  logic clk = 1'b0, rst = 1'b1, ce = 1'b1, wr = 1'b0, rd = 1'b0, wdog = 1'b0;
  logic rail = 1'b1, run = 1'b0, gb = 1'b0, gp = 1'b1, cb = 1'b1, cp = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata;
  logic [2:0] src;
  logic pfe, ien, refsw, go, goe, co, coe, xp1, xp2, xen, sen;
  int n_mismatch = 0, tests_run = 0, cycles = 0;
  logic [7:0] tst [5] = '{8'h04, 8'h0C, 8'h10, 8'h14, 8'h1C};
  logic [5:0] md [7] = '{6'h00, 6'h02, 6'h06, 6'h04, 6'h03, 6'h17, 6'h0C};
  bbrb_src_e ex [7] = '{BBRB_SRC_OFF, BBRB_SRC_XTAL, BBRB_SRC_XTAL,
    BBRB_SRC_INT, BBRB_SRC_SE, BBRB_SRC_SE, BBRB_SRC_INT};
  always #5 clk = ~clk;
  bbrb_pad_model u_pad (.run(run), .se_mode(1'b1), .first_pin(xp1),
    .second_pin(xp2));
  bbrb_bank DUT (.SYS_CLK(clk), .SYS_RST(rst), .CLK_EN(ce), .REG_ADDR(addr),
    .REG_WR(wr), .REG_RD(rd), .REG_WDATA(wdata), .REG_RDATA(rdata),
    .WATCHDOG_RESET(wdog), .MAIN_SUPPLY_RAIL(rail), .FIRST_CRYSTAL_PIN(xp1),
    .SECOND_CRYSTAL_PIN(xp2), .GENERAL_BATT_VALUE(gb), .GENERAL_PIN_CTRL(gp),
    .CTRL_BATT_VALUE(cb), .CTRL_PIN_CTRL(cp), .POWER_FAIL_EVENT(pfe),
    .XTAL_OSC_EN(xen), .SE_INPUT_EN(sen), .INT_OSC_EN(ien), .SLOW_CLK_OUT(),
    .REF_USES_SWITCHED(refsw), .SLOW_SRC(src), .BATTERY_GENERAL_OUTPUT(go),
    .BATTERY_GENERAL_OUTPUT_OE_N(goe), .BATTERY_CONTROL_OUTPUT(co),
    .BATTERY_CONTROL_OUTPUT_OE_N(coe));
  // ==========================================================
  // tasks
  task automatic chk(input string what, input logic [31:0] exp,
                     input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic wreg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk) begin addr <= a; wdata <= d; wr <= 1'b1; end
    @(posedge clk) wr <= 1'b0;
  endtask : wreg
  task automatic rreg(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk) begin addr <= a; rd <= 1'b1; end
    @(posedge clk) rd <= 1'b0;
    @(posedge clk) #1;
    chk("rdata", exp, rdata);
  endtask : rreg
  task automatic settle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : settle
  task automatic conclude;
    $display("mismatches %0d in %0d checks", n_mismatch, tests_run);
    if (n_mismatch == 0 && tests_run > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : conclude
  // hang guard: the sequence needs about 5900 cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      n_mismatch++;
      conclude();
    end
  end
  // ==========================================================
  // sequence
  initial begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    rreg(8'h00, 32'h80);
    rreg(8'h08, 32'h0);
    rreg(8'h18, 32'h3);
    foreach (tst[i]) begin
      wreg(tst[i], '1);
      rreg(tst[i], 32'h0);
    end
    wreg(8'h00, 32'h0);
    rreg(8'h00, 32'h80);
    wreg(8'h00, 32'h80);
    rreg(8'h00, 32'h0);
    chk("event", 0, pfe);
    @(posedge clk) wdog <= 1'b1;
    @(posedge clk) wdog <= 1'b0;
    rreg(8'h00, 32'h20);
    chk("event", 1, pfe);
    wreg(8'h00, 32'h80);
    rreg(8'h00, 32'h20);
    wreg(8'h00, 32'h20);
    rreg(8'h00, 32'h0);
    foreach (md[i]) begin
      wreg(8'h08, {26'h0, md[i]});
      settle(3);
      chk("source", {29'h0, ex[i]}, {29'h0, src});
      chk("xtalen", ex[i] == BBRB_SRC_XTAL, xen);
      chk("seen", ex[i] == BBRB_SRC_SE, sen);
    end
    wreg(8'h08, '1);
    rreg(8'h08, 32'h3F);
    chk("refsel", 1, refsw);
    @(posedge clk) run <= 1'b1;
    wreg(8'h08, 32'h07);
    settle(400);
    chk("source", BBRB_SRC_SE, {29'h0, src});
    rreg(8'h00, 32'h1);
    @(posedge clk) run <= 1'b0;
    settle(4300);
    chk("source", BBRB_SRC_INT, {29'h0, src});
    rreg(8'h00, 32'h0);
    @(posedge clk) run <= 1'b1;
    settle(1000);
    chk("source", BBRB_SRC_SE, {29'h0, src});
    @(posedge clk) rail <= 1'b0;
    settle(5);
    chk("source", BBRB_SRC_INT, {29'h0, src});
    wreg(8'h08, 32'h0C);
    settle(5);
    chk("intosc", 0, ien);
    wreg(8'h08, 32'h04);
    settle(5);
    chk("intosc", 1, ien);
    wreg(8'h18, 32'h0);
    settle(5);
    chk("pins", 2'b11, {goe, coe});
    @(posedge clk) rail <= 1'b1;
    settle(5);
    chk("pins", 4'b1000, {go, goe, co, coe});
    @(posedge clk) ce <= 1'b0;
    wreg(8'h18, 32'h3);
    @(posedge clk) ce <= 1'b1;
    rreg(8'h18, 32'h0);
    wreg(8'h18, 32'h3);
    settle(3);
    chk("pins", 4'b0010, {go, goe, co, coe});
    wreg(8'h08, 32'h3F);
    @(posedge clk) run <= 1'b0;
    @(posedge clk) rst <= 1'b1;
    @(posedge clk) rst <= 1'b0;
    rreg(8'h08, 32'h0);
    rreg(8'h00, 32'h80);
    @(posedge clk) wdog <= 1'b1;
    @(posedge clk) wdog <= 1'b0;
    wreg(8'h00, 32'hA0);
    rreg(8'h00, 32'h0);
    chk("event", 0, pfe);
    conclude();
  end
endmodule : bbrb_bank_tb_top
